// [verilog/ccs_sequencer.v]
// configuration sequencer: memory clear, frame load, readback and start-up release
`timescale 1ns/1ps
`include "ccs_defs.vh"
module ccs_sequencer #(
    parameter [23:0] LOAD_BITS = 24'd559232
) (
    input  wire                     core_clk,
    input  wire                     srst,
    input  wire                     restart_n,
    input  wire                     clear_status_in,
    output wire                     clear_status_out,
    output wire                     clear_status_oe,
    input  wire                     done_in,
    output wire                     done_out,
    output wire                     done_oe,
    input  wire [`CCS_DLL_W-1:0]    dll_locked,
    input  wire [`CCS_DATA_W-1:0]   user_state,
    output reg                      global_output_float,
    output reg                      global_state_reset,
    output reg                      global_store_enable,
    input  wire [`CCS_ADDR_W-1:0]   reg_addr,
    input  wire [`CCS_DATA_W-1:0]   reg_wdata,
    input  wire                     reg_wr,
    input  wire                     reg_rd,
    output reg  [`CCS_DATA_W-1:0]   reg_rdata
);

    localparam [2:0] PH_CLEAR   = 3'h0;
    localparam [2:0] PH_INIT    = 3'h1;
    localparam [2:0] PH_LOAD    = 3'h2;
    localparam [2:0] PH_STARTUP = 3'h3;
    localparam [2:0] PH_RUN     = 3'h4;

    localparam integer          IDX_LAST_I = `CCS_MEM_WORDS - 1;
    localparam [`CCS_IDX_W-1:0] IDX_LAST   = IDX_LAST_I[`CCS_IDX_W-1:0];

    // true once the stage about to be entered has reached a release field
    function reached;
        input [`CCS_STAGE_W-1:0] stage;
        input [`CCS_STAGE_W-1:0] field;
        begin
            reached = (stage >= field);
        end
    endfunction

    // pin synchronisers: first stage is read only by the second
    reg                    restart_m_q, restart_s_q;
    reg                    init_m_q,    init_s_q;
    reg                    donep_m_q,   donep_s_q;
    reg [`CCS_DLL_W-1:0]   dll_m_q,     dll_s_q;

    always @(posedge core_clk) begin
        if (srst) begin
            restart_m_q <= 1'b0;
            restart_s_q <= 1'b0;
            init_m_q    <= 1'b0;
            init_s_q    <= 1'b0;
            donep_m_q   <= 1'b0;
            donep_s_q   <= 1'b0;
            dll_m_q     <= 4'h0;
            dll_s_q     <= 4'h0;
        end else begin
            restart_m_q <= restart_n;
            restart_s_q <= restart_m_q;
            init_m_q    <= clear_status_in;
            init_s_q    <= init_m_q;
            donep_m_q   <= done_in;
            donep_s_q   <= donep_m_q;
            dll_m_q     <= dll_locked;
            dll_s_q     <= dll_m_q;
        end
    end

    reg [2:0]                phase_q;
    reg [`CCS_IDX_W-1:0]     clr_idx_q;
    reg                      pass_ok_q;
    reg [`CCS_IDX_W-1:0]     frame_idx_q;
    reg [`CCS_BITS_W-1:0]    bit_cnt_q;
    reg [`CCS_STAGE_W-1:0]   stage_q;
    reg                      done_q;
    reg [`CCS_CTRL_W-1:0]    ctrl_q;

    wire [`CCS_STAGE_W-1:0] fld_float  = ctrl_q[`CCS_CTRL_FLOAT_LSB +: `CCS_STAGE_W];
    wire [`CCS_STAGE_W-1:0] fld_reset  = ctrl_q[`CCS_CTRL_RESET_LSB +: `CCS_STAGE_W];
    wire [`CCS_STAGE_W-1:0] fld_store  = ctrl_q[`CCS_CTRL_STORE_LSB +: `CCS_STAGE_W];
    wire                    sync_en    = ctrl_q[`CCS_CTRL_SYNC_BIT];
    wire                    dll_en     = ctrl_q[`CCS_CTRL_DLLEN_BIT];
    wire [`CCS_STAGE_W-1:0] dll_stage  = ctrl_q[`CCS_CTRL_DLLSTG_LSB +: `CCS_STAGE_W];
    wire [`CCS_DLL_W-1:0]   dll_mask   = ctrl_q[`CCS_CTRL_MASK_LSB +: `CCS_DLL_W];

    wire in_clear   = (phase_q == PH_CLEAR);
    wire restart_lo = ~restart_s_q;

    // register access decode
    wire wr_ctrl  = reg_wr && (reg_addr == `CCS_REG_CTRL);
    wire wr_idx   = reg_wr && (reg_addr == `CCS_REG_FRAME_IDX);
    wire wr_frame = reg_wr && (reg_addr == `CCS_REG_FRAME_DAT) && (phase_q == PH_LOAD);
    wire rd_frame = reg_rd && (reg_addr == `CCS_REG_FRAME_DAT) && !in_clear;

    // the store is written by the clear sweep or by frame loads, never both
    wire                    mem_wr_en   = in_clear | wr_frame;
    wire [`CCS_IDX_W-1:0]   mem_wr_idx  = in_clear ? clr_idx_q : frame_idx_q;
    wire [`CCS_DATA_W-1:0]  mem_wr_data = in_clear ? {`CCS_DATA_W{1'b0}} : reg_wdata;
    wire [`CCS_DATA_W-1:0]  mem_rd_data;

    ccs_frame_mem u_mem (
        .core_clk (core_clk),
        .wr_en    (mem_wr_en),
        .wr_idx   (mem_wr_idx),
        .wr_data  (mem_wr_data),
        .rd_idx   (frame_idx_q),
        .rd_data  (mem_rd_data)
    );

    // start-up advance conditions
    wire dll_hold  = dll_en && (stage_q == dll_stage)
                     && ((dll_s_q & dll_mask) != dll_mask);
    wire sync_hold = sync_en && !donep_s_q;
    wire advance   = (phase_q == PH_STARTUP) && !dll_hold && !sync_hold;
    wire [`CCS_STAGE_W-1:0] stage_nx = stage_q + 3'h1;

    wire [`CCS_BITS_W-1:0] bits_nx = bit_cnt_q + `CCS_BITS_PER_WORD;
    wire                   load_full = (bits_nx >= LOAD_BITS);

    always @(posedge core_clk) begin
        if (srst) begin
            phase_q     <= PH_CLEAR;
            clr_idx_q   <= 4'h0;
            pass_ok_q   <= 1'b0;
            frame_idx_q <= 4'h0;
            bit_cnt_q   <= 24'h000000;
            stage_q     <= 3'h0;
            done_q      <= 1'b0;
            global_output_float <= 1'b1;
            global_state_reset  <= 1'b1;
            global_store_enable <= 1'b0;
        end else if (restart_lo && !in_clear) begin
            // restart pin aborts whatever is running and starts over
            phase_q     <= PH_CLEAR;
            clr_idx_q   <= 4'h0;
            pass_ok_q   <= 1'b0;
            bit_cnt_q   <= 24'h000000;
            stage_q     <= 3'h0;
            done_q      <= 1'b0;
            global_output_float <= 1'b1;
            global_state_reset  <= 1'b1;
            global_store_enable <= 1'b0;
        end else begin
            if (wr_idx) begin
                frame_idx_q <= reg_wdata[`CCS_IDX_W-1:0];
            end else if (wr_frame || rd_frame) begin
                frame_idx_q <= frame_idx_q + 4'h1;
            end
            case (phase_q)
                PH_CLEAR: begin
                    // sweep never stops; a pass counts only if restart was high throughout
                    clr_idx_q <= clr_idx_q + 4'h1;
                    if (clr_idx_q == 4'h0) begin
                        pass_ok_q <= restart_s_q;
                    end else if (restart_lo) begin
                        pass_ok_q <= 1'b0;
                    end
                    if ((clr_idx_q == IDX_LAST) && pass_ok_q && restart_s_q) begin
                        phase_q <= PH_INIT;
                    end
                end
                PH_INIT: begin
                    // pin still low means someone outside holds it
                    if (init_s_q) begin
                        phase_q     <= PH_LOAD;
                        frame_idx_q <= 4'h0;
                    end
                end
                PH_LOAD: begin
                    if (wr_frame) begin
                        bit_cnt_q <= bits_nx;
                        if (load_full) begin
                            phase_q <= PH_STARTUP;
                            done_q  <= 1'b1;
                            stage_q <= 3'h0;
                        end
                    end
                end
                PH_STARTUP: begin
                    if (advance) begin
                        stage_q <= stage_nx;
                        if (reached(stage_nx, fld_float)) begin
                            global_output_float <= 1'b0;
                        end
                        if (reached(stage_nx, fld_reset)) begin
                            global_state_reset <= 1'b0;
                        end
                        if (reached(stage_nx, fld_store)) begin
                            global_store_enable <= 1'b1;
                        end
                        if (stage_q == `CCS_STAGE_LAST) begin
                            phase_q             <= PH_RUN;
                            global_output_float <= 1'b0;
                            global_state_reset  <= 1'b0;
                            global_store_enable <= 1'b1;
                        end
                    end
                end
                PH_RUN: begin
                    phase_q <= PH_RUN;
                end
                default: begin
                    phase_q <= PH_CLEAR;
                end
            endcase
        end
    end

    // open-drain pins: only ever pull low, release means high through the pull-up
    assign clear_status_out = 1'b0;
    assign clear_status_oe  = in_clear;
    assign done_out         = 1'b0;
    assign done_oe          = ~done_q;

    // control register and read port
    always @(posedge core_clk) begin
        if (srst) begin
            ctrl_q <= `CCS_CTRL_RESET_VAL;
        end else if (wr_ctrl) begin
            ctrl_q <= reg_wdata[`CCS_CTRL_W-1:0];
        end
    end

    reg [`CCS_DATA_W-1:0] rdata_d;

    always @* begin
        rdata_d = 32'h00000000;
        case (reg_addr)
            `CCS_REG_CTRL: begin
                rdata_d[`CCS_CTRL_W-1:0] = ctrl_q;
            end
            `CCS_REG_STATUS: begin
                rdata_d[2:0]   = phase_q;
                rdata_d[3]     = done_q;
                rdata_d[4]     = init_s_q;
                rdata_d[7:5]   = stage_q;
                rdata_d[8]     = global_output_float;
                rdata_d[9]     = global_state_reset;
                rdata_d[10]    = global_store_enable;
                rdata_d[14:11] = dll_s_q;
                rdata_d[15]    = donep_s_q;
            end
            `CCS_REG_FRAME_IDX: begin
                rdata_d[`CCS_IDX_W-1:0] = frame_idx_q;
            end
            `CCS_REG_FRAME_DAT: begin
                // memory is being wiped during clear, so readback shows zero then
                if (!in_clear) begin
                    rdata_d = mem_rd_data;
                end
            end
            `CCS_REG_BIT_COUNT: begin
                rdata_d[`CCS_BITS_W-1:0] = bit_cnt_q;
            end
            `CCS_REG_USER_SNAP: begin
                rdata_d = user_state;
            end
            default: begin
                rdata_d = 32'h00000000;
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (srst) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end
endmodule // ccs_sequencer

// [verilog/ccs_defs.vh]
// constants and register map for the configuration clear and start-up sequencer
//
// Contract
// - while restart is low, keep cycling through every memory address clearing it
// - after restart rises, finish one full clearing pass before leaving clear
// - drive clear-status low, open-drain, for the whole clearing time
// - clear-status held low from outside blocks entry to data loading
// - default order: release output float one cycle after completion goes high
// - default: release state reset and store enable together one cycle later
// - release timing of float, reset and store enable is reconfigurable
// - option: release events wait until all shared completion pins are high
// - option: pause start-up at a chosen stage until selected loops lock
// - accept frames loaded in sequence up to a fixed total bit count
// - support readback of stored frames and of live user storage state
// - configure automatically at power-up and again whenever restart is asserted
// - release clear-status after clearing; raise completion when configuration ends
`ifndef CCS_DEFS_VH
`define CCS_DEFS_VH

`define CCS_ADDR_W        8
`define CCS_DATA_W        32
`define CCS_MEM_WORDS     16
`define CCS_IDX_W         4
`define CCS_BITS_W        24
`define CCS_BITS_PER_WORD 24'h000020
`define CCS_LOAD_BITS_MIN 559232
`define CCS_LOAD_BITS_MAX 6127776

`define CCS_REG_CTRL      8'h00
`define CCS_REG_STATUS    8'h04
`define CCS_REG_FRAME_IDX 8'h08
`define CCS_REG_FRAME_DAT 8'h0c
`define CCS_REG_BIT_COUNT 8'h10
`define CCS_REG_USER_SNAP 8'h14

`define CCS_CTRL_FLOAT_LSB  0
`define CCS_CTRL_RESET_LSB  3
`define CCS_CTRL_STORE_LSB  6
`define CCS_CTRL_SYNC_BIT   9
`define CCS_CTRL_DLLEN_BIT  10
`define CCS_CTRL_DLLSTG_LSB 11
`define CCS_CTRL_MASK_LSB   16
`define CCS_CTRL_W          20
`define CCS_CTRL_RESET_VAL  20'h00091

`define CCS_STAGE_W       3
`define CCS_STAGE_LAST    3'h7
`define CCS_DLL_W         4

`endif

// [verilog/ccs_frame_mem.v]
// flip-flop frame store with one write port and one combinational read port
`timescale 1ns/1ps
module ccs_frame_mem (
    core_clk,
    wr_en,
    wr_idx,
    wr_data,
    rd_idx,
    rd_data
);
`include "ccs_defs.vh"
    input  wire                     core_clk;
    input  wire                     wr_en;
    input  wire [`CCS_IDX_W-1:0]    wr_idx;
    input  wire [`CCS_DATA_W-1:0]   wr_data;
    input  wire [`CCS_IDX_W-1:0]    rd_idx;
    output wire [`CCS_DATA_W-1:0]   rd_data;

    reg [`CCS_DATA_W-1:0] mem_q [0:`CCS_MEM_WORDS-1];

    genvar g;
    generate
        for (g = 0; g < `CCS_MEM_WORDS; g = g + 1) begin : g_word
            always @(posedge core_clk) begin
                if (wr_en && ({{(32-`CCS_IDX_W){1'b0}}, wr_idx} == g)) begin
                    mem_q[g] <= wr_data;
                end
            end
        end
    endgenerate

    // no reset on the store: the clear phase wipes it
    assign rd_data = mem_q[rd_idx];
endmodule // ccs_frame_mem

// [verif/ccs_seq_chk.sv]
// assertion checker for the configuration clear and start-up sequencer
`timescale 1ns/1ps
module ccs_seq_chk #(
    parameter [23:0] LOAD_BITS = 24'd559232
) (
    input wire        core_clk,
    input wire        srst,
    input wire        restart_n,
    input wire        clear_status_out,
    input wire        clear_status_oe,
    input wire        done_in,
    input wire        done_out,
    input wire        done_oe,
    input wire        global_output_float,
    input wire        global_state_reset,
    input wire        global_store_enable,
    input wire [7:0]  reg_addr,
    input wire [31:0] reg_wdata,
    input wire        reg_wr
);
    reg       dflt_q;
    reg       sync_q;
    reg [7:0] run_q;
    // ctrl is not visible at the pins, so shadow the writes to it
    always @(posedge core_clk) begin
        if (srst) begin
            dflt_q <= 1'b1;
            sync_q <= 1'b0;
        end else if (reg_wr && reg_addr == 8'h00) begin
            dflt_q <= (reg_wdata[19:0] == 20'h00091);
            sync_q <= reg_wdata[9];
        end
    end
    always @(posedge core_clk) begin
        if (srst || !restart_n || !clear_status_oe)
            run_q <= 8'h00;
        else if (run_q != 8'hff)
            run_q <= run_q + 8'h01;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    restart_clr_a: assert property (!restart_n |-> ##[2:3] clear_status_oe)
        else $error("clear-status released while restart low");
    restart_glob_a: assert property (!restart_n [*3] |=> done_oe && global_output_float)
        else $error("restart did not reassert the globals");
    pass_len_a: assert property ($fell(clear_status_oe) |-> run_q >= 8'd16)
        else $error("clearing left before a full pass");
    pass_end_a: assert property ($rose(restart_n) |-> clear_status_oe [*8] ##[8:40] !clear_status_oe)
        else $error("clearing did not end after restart rose");
    held_glob_a: assert property (done_oe |-> global_output_float && global_state_reset && !global_store_enable)
        else $error("globals released before completion");
    open_drain_a: assert property (clear_status_out == 1'b0 && done_out == 1'b0)
        else $error("open-drain pin driven high");
    clr_first_a: assert property ($fell(clear_status_oe) |-> done_oe)
        else $error("completion raised during clearing");
    dflt_order_a: assert property ($fell(done_oe) && dflt_q |-> global_output_float ##1 (!global_output_float && global_state_reset) ##1 (!global_state_reset && global_store_enable))
        else $error("default release order broken");
    sync_hold_a: assert property (sync_q && (restart_n && !done_in) [*3] |=> $stable({global_output_float, global_state_reset, global_store_enable}))
        else $error("release while completion wire low");
    cover property ($fell(done_oe));
    cover property ($rose(restart_n));
    cover property (sync_q && !done_in && !done_oe);
endmodule // ccs_seq_chk

bind ccs_sequencer ccs_seq_chk #(.LOAD_BITS(LOAD_BITS)) i_chk (
    .core_clk(core_clk), .srst(srst), .restart_n(restart_n),
    .clear_status_out(clear_status_out), .clear_status_oe(clear_status_oe),
    .done_in(done_in), .done_out(done_out), .done_oe(done_oe),
    .global_output_float(global_output_float), .global_state_reset(global_state_reset),
    .global_store_enable(global_store_enable), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr));

// [verif/ccs_sys_ctrl.sv]
// system controller model: restart pin and pulls on the shared open-drain wires
`timescale 1ns/1ps
module ccs_sys_ctrl (
    input  wire core_clk,
    input  wire want_restart,
    input  wire hold_clear,
    input  wire hold_done,
    input  wire clear_oe,
    input  wire done_oe,
    output reg  restart_n,
    output wire clear_wire,
    output wire done_wire
);
    initial restart_n = 1'b1;
    // restart may be held low as long as the system is not ready
    always @(posedge core_clk) begin
        restart_n <= !want_restart;
    end
    // pulls only ever go low; the pull-up gives the high level
    assign clear_wire = !(clear_oe || hold_clear);
    assign done_wire  = !(done_oe || hold_done);
endmodule // ccs_sys_ctrl

// [verif/testbench.sv]
// self-checking testbench for the configuration clear and start-up sequencer
`timescale 1ns/1ps
`include "ccs_defs.vh"
module testbench;
    reg         core_clk, srst, want_restart, hold_clear, hold_done, reg_wr, reg_rd;
    reg  [3:0]  dll_locked;
    reg  [7:0]  reg_addr;
    reg  [31:0] reg_wdata, rv;
    wire        restart_n, clear_status_in, clear_status_oe, done_in, done_oe;
    wire        global_output_float, global_state_reset, global_store_enable;
    wire [31:0] reg_rdata;
    integer     fails, num_checks, cyc, n, i;
    // three words end the load, keeping start-up short
    ccs_sequencer #(.LOAD_BITS(24'd96)) i_dut (.core_clk(core_clk), .srst(srst),
        .restart_n(restart_n), .clear_status_in(clear_status_in), .clear_status_out(),
        .clear_status_oe(clear_status_oe), .done_in(done_in), .done_out(), .done_oe(done_oe),
        .dll_locked(dll_locked), .user_state(32'h5a5a0f0f),
        .global_output_float(global_output_float), .global_state_reset(global_state_reset),
        .global_store_enable(global_store_enable), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    ccs_sys_ctrl i_sys (.core_clk(core_clk), .want_restart(want_restart),
        .hold_clear(hold_clear), .hold_done(hold_done), .clear_oe(clear_status_oe),
        .done_oe(done_oe), .restart_n(restart_n), .clear_wire(clear_status_in),
        .done_wire(done_in));
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = !core_clk;
    end
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            fails = fails + 1;
            conclude;
        end
    end
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge core_clk);
            reg_wr    <= 1'b1;
            reg_addr  <= a;
            reg_wdata <= d;
            @(posedge core_clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(posedge core_clk);
            reg_rd   <= 1'b1;
            reg_addr <= a;
            @(posedge core_clk);
            reg_rd <= 1'b0;
            @(negedge core_clk);
            rv = reg_rdata;
        end
    endtask
    task wait_oe_low;
        begin
            n = 0;
            @(negedge core_clk);
            while (clear_status_oe !== 1'b0 && n < 100) begin
                @(negedge core_clk);
                n = n + 1;
            end
        end
    endtask
    task load;
        for (i = 0; i < 3; i = i + 1)
            wr(`CCS_REG_FRAME_DAT, 32'hc0de0000 + i);
    endtask
    task conclude;
        begin
            $display("checks %0d mismatches %0d", num_checks, fails);
            if (fails == 0 && num_checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial begin
        {fails, num_checks, cyc} = 0;
        {srst, hold_clear} = 2'b11;
        {want_restart, hold_done, reg_wr, reg_rd} = 4'b0000;
        {dll_locked, reg_addr, reg_wdata} = 0;
        repeat (6) @(posedge core_clk);
        srst <= 1'b0;
        rd(`CCS_REG_CTRL);
        chk(rv, 32'h00091);
        wait_oe_low;
        chk(n >= 16 && n < 100, 1);
        // the controller still pulls clear-status low, so loading must wait
        repeat (8) @(posedge core_clk);
        wr(`CCS_REG_FRAME_DAT, 32'h11111111);
        rd(`CCS_REG_STATUS);
        chk(rv & 32'h7, 32'h1);
        rd(`CCS_REG_BIT_COUNT);
        chk(rv, 32'h0);
        hold_clear <= 1'b0;
        repeat (6) @(posedge core_clk);
        rd(`CCS_REG_STATUS);
        chk(rv & 32'h7, 32'h2);
        load;
        repeat (12) @(posedge core_clk);
        chk({global_output_float, global_state_reset, global_store_enable, done_oe}, 4'h2);
        rd(`CCS_REG_STATUS);
        chk(rv & 32'h7, 32'h4);
        rd(`CCS_REG_BIT_COUNT);
        chk(rv, 32'd96);
        wr(`CCS_REG_FRAME_IDX, 32'h0);
        for (i = 0; i < 3; i = i + 1) begin
            rd(`CCS_REG_FRAME_DAT);
            chk(rv, 32'hc0de0000 + i);
        end
        rd(`CCS_REG_USER_SNAP);
        chk(rv, 32'h5a5a0f0f);
        rd(8'h1c);
        chk(rv, 32'h0);
        want_restart <= 1'b1;
        repeat (30) @(posedge core_clk);
        chk({clear_status_oe, done_oe, global_output_float, global_store_enable}, 4'he);
        want_restart <= 1'b0;
        wait_oe_low;
        chk(n >= 16 && n < 100, 1);
        // reset first, float at stage 3, store after dll 0 locks at stage 4
        wr(`CCS_REG_CTRL, 32'h1274b);
        hold_done <= 1'b1;
        repeat (8) @(posedge core_clk);
        load;
        repeat (10) @(posedge core_clk);
        chk({global_output_float, global_state_reset, global_store_enable}, 3'b110);
        hold_done <= 1'b0;
        n = 0;
        while (global_state_reset !== 1'b0 && n < 20) begin
            @(negedge core_clk);
            n = n + 1;
        end
        chk({global_state_reset, global_output_float}, 2'b01);
        repeat (10) @(posedge core_clk);
        chk({global_output_float, global_store_enable}, 2'b00);
        dll_locked <= 4'h1;
        repeat (6) @(posedge core_clk);
        chk({global_output_float, global_state_reset, global_store_enable}, 3'b001);
        conclude;
    end
endmodule // testbench
